// ### shared/r8dp_map.svh
// Offsets, flag positions, reset values and pointer indices of the core.
// Assumes inclusion by bare name from the package or the core.
`ifndef R8DP_MAP_SVH
`define R8DP_MAP_SVH

`define R8DP_NREGS      32
`define R8DP_FLAG_C     3'd0
`define R8DP_FLAG_Z     3'd1
`define R8DP_FLAG_N     3'd2
`define R8DP_FLAG_V     3'd3
`define R8DP_FLAG_S     3'd4
`define R8DP_FLAG_H     3'd5
`define R8DP_FLAG_T     3'd6
`define R8DP_FLAG_I     3'd7
`define R8DP_FLAGS_RST  8'h00
`define R8DP_PC_RST     16'h0000
`define R8DP_IR_RST     16'h0000
`define R8DP_PTR_X      5'h1A
`define R8DP_PTR_Y      5'h1C
`define R8DP_PTR_Z      5'h1E
`define R8DP_PTR_W      5'h18
`define R8DP_MUL_LO     5'h00
`define R8DP_IMM_BASE   5'h10

`endif

// ### shared/r8dp_pkg.sv
// Types shared by the core datapath and its bench.
// Assumes r8dp_map.svh sits on the include path.
package r8dp_pkg;
   `include "r8dp_map.svh"

   typedef enum logic [3:0] {
      OP_NOP  = 4'b0000,
      OP_ARI  = 4'b0001,
      OP_LOG  = 4'b0010,
      OP_ONE  = 4'b0011,
      OP_MUL  = 4'b0100,
      OP_ADW  = 4'b0101,
      OP_LDI  = 4'b0110,
      OP_SBI  = 4'b0111,
      OP_LD   = 4'b1000,
      OP_ST   = 4'b1001,
      OP_TBL  = 4'b1010,
      OP_JMP  = 4'b1011,
      OP_BRS  = 4'b1100,
      OP_BRC  = 4'b1101,
      OP_RS0  = 4'b1110,
      OP_RS1  = 4'b1111
   } r8dp_op_t;

   typedef enum logic [1:0] {
      ST_RUN  = 2'b00,
      ST_LOAD = 2'b01,
      ST_TBL  = 2'b10
   } r8dp_state_t;

   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       h;
      logic       v;
   } r8dp_alu_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } r8dp_dbus_t;
endpackage

// ### logic/r8dp_core.sv
// Execution datapath of the 8-bit core: fetch, register file, ALU, flags.
// Assumes flash and data memory answer combinationally on MCLK's domain.
//
// What this block does
// (RULE1) Separate program and data buses, same cycle
// (RULE2) Next instruction fetched while current executes
// (RULE3) One instruction completes per clock, except loads, table reads, jumps and taken branches
// (RULE4) Thirty-two eight-bit working registers
// (RULE5) Register read and write within one clock
// (RULE6) Two operands read, result written, one clock
// (RULE7) Any two registers feed the ALU
// (RULE8) Three register pairs address data space
// (RULE9) Z pair also addresses flash tables
// (RULE10) Four operand schemes: 8/8, 8+8/8, 8+8/16, 16/16
// (RULE11) Status flags updated after ALU operations
// (RULE12) Sign flag equals negative xor overflow
// (RULE13) Taken jump flushes prefetched instruction
// (RULE14) Pointer low byte from lower register
`timescale 1ns/1ps
`include "r8dp_map.svh"
module r8dp_core
   import r8dp_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RST_B,
   output logic [15:0]      PROG_ADDR,
   input  wire logic [15:0] PROG_DATA,
   output r8dp_dbus_t       DATA_BUS,
   input  wire logic [7:0]  DATA_RDATA,
   output logic [7:0]       STATUS_FLAGS
);
   logic [7:0]  rf_reg   [`R8DP_NREGS];
   logic [7:0]  rf_next  [`R8DP_NREGS];
   logic [7:0]  status_flags_register_reg;
   logic [7:0]  status_flags_register_next;
   logic [15:0] paddr_reg;
   logic [15:0] paddr_next;
   logic [15:0] ir_reg;
   logic [15:0] ir_next;
   logic        irv_reg;
   logic        irv_next;
   logic [4:0]  dst_reg;
   logic [4:0]  dst_next;
   r8dp_state_t state_reg;
   r8dp_state_t state_next;
   r8dp_dbus_t  dbus_reg;
   r8dp_dbus_t  dbus_next;

   r8dp_op_t    op;
   logic [4:0]  rd, rr, rdi;
   logic [7:0]  a, b, kimm;
   r8dp_alu_t   alu;
   logic [15:0] wide;
   logic [16:0] wsum;
   logic [4:0]  ptr;
   logic        stall, redirect;
   logic [15:0] target;
   logic        cf, vf, nf, zf;
   logic        upd_znv, upd_c, upd_h;

   // Shared by add, adc, sub, sbc, immediate subtract, inc and dec
   function automatic r8dp_alu_t add_sub(input logic [7:0] x, input logic [7:0] y,
                                          input logic cin, input logic sub);
      r8dp_alu_t  o;
      logic [8:0] s;
      logic [4:0] n;
      if (sub) begin
         s = {1'b0, x} - {1'b0, y} - {8'h00, cin};
         n = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, cin};
         o.v = (x[7] & ~y[7] & ~s[7]) | (~x[7] & y[7] & s[7]);
      end else begin
         s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
         n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
         o.v = (x[7] & y[7] & ~s[7]) | (~x[7] & ~y[7] & s[7]);
      end
      o.res = s[7:0];
      o.c   = s[8];
      o.h   = n[4];
      return o;
   endfunction

   // Pair at lo: lower register is the low byte [RULE14]
   function automatic logic [15:0] pair16(input logic [4:0] lo);
      return {rf_reg[5'(lo + 5'h01)], rf_reg[lo]};
   endfunction

   assign op   = r8dp_op_t'(ir_reg[15:12]);
   assign rd   = ir_reg[9:5];
   assign rr   = ir_reg[4:0];
   assign rdi  = {1'b1, ir_reg[11:8]};
   assign kimm = ir_reg[7:0];
   assign a    = rf_reg[rd];  // [RULE7]
   assign b    = rf_reg[rr];  // [RULE7]

   always_comb begin
      rf_next = rf_reg;
      status_flags_register_next = status_flags_register_reg;
      dbus_next    = dbus_reg;
      dbus_next.we = 1'b0;
      dbus_next.re = 1'b0;
      dst_next     = dst_reg;
      state_next   = state_reg;
      ir_next      = ir_reg;
      irv_next     = irv_reg;
      paddr_next   = paddr_reg;
      alu      = '0;
      wide     = 16'h0000;
      wsum     = 17'h00000;
      ptr      = `R8DP_PTR_X;
      stall    = 1'b0;
      redirect = 1'b0;
      target   = paddr_reg;
      cf = status_flags_register_reg[`R8DP_FLAG_C];
      vf = 1'b0;
      nf = 1'b0;
      zf = 1'b0;
      upd_znv = 1'b0;
      upd_c   = 1'b0;
      upd_h   = 1'b0;
      unique case (state_reg)
         ST_RUN: begin
            if (irv_reg) begin
               unique case (op)
                  OP_ARI: begin
                     // Two 8-bit operands, 8-bit result, one clock [RULE6] [RULE10]
                     alu = add_sub(a, b, ir_reg[10] & cf, ir_reg[11]);
                     rf_next[rd] = alu.res;
                     upd_znv = 1'b1;
                     upd_c   = 1'b1;
                     upd_h   = 1'b1;
                  end
                  OP_LOG: begin
                     unique case (ir_reg[11:10])
                        2'b00: alu.res = a & b;
                        2'b01: alu.res = a | b;
                        2'b10: alu.res = a ^ b;
                        2'b11: alu.res = b;
                     endcase
                     rf_next[rd] = alu.res;
                     upd_znv = (ir_reg[11:10] != 2'b11);  // Move leaves flags alone
                  end
                  OP_ONE: begin
                     // One 8-bit operand, 8-bit result [RULE10]
                     unique case (ir_reg[11:10])
                        2'b00: alu = add_sub(a, 8'h01, 1'b0, 1'b0);
                        2'b01: alu = add_sub(a, 8'h01, 1'b0, 1'b1);
                        2'b10: begin
                           alu.res = {1'b0, a[7:1]};
                           alu.c   = a[0];
                           alu.v   = a[0];  // N is zero, so V = N ^ C
                           upd_c   = 1'b1;
                        end
                        2'b11: begin
                           alu.res = ~a;
                           alu.c   = 1'b1;
                           upd_c   = 1'b1;
                        end
                     endcase
                     rf_next[rd] = alu.res;
                     upd_znv = 1'b1;
                  end
                  OP_MUL: begin
                     // Two 8-bit operands, 16-bit result into R1:R0 [RULE10]
                     wide = {8'h00, a} * {8'h00, b};
                     rf_next[`R8DP_MUL_LO]          = wide[7:0];
                     rf_next[`R8DP_MUL_LO + 5'h01]  = wide[15:8];
                     cf    = wide[15];
                     zf    = (wide == 16'h0000);
                     upd_c = 1'b1;
                  end
                  OP_ADW: begin
                     // One 16-bit operand, 16-bit result [RULE10] [RULE14]
                     ptr  = `R8DP_PTR_W + {2'b00, ir_reg[7:6], 1'b0};
                     wsum = {1'b0, pair16(ptr)} + {11'h000, ir_reg[5:0]};
                     rf_next[ptr]                = wsum[7:0];
                     rf_next[5'(ptr + 5'h01)]    = wsum[15:8];
                     alu.res = wsum[15:8];
                     alu.c   = wsum[16];
                     alu.v   = ~rf_reg[5'(ptr + 5'h01)][7] & wsum[15];
                     upd_znv = 1'b1;
                     upd_c   = 1'b1;
                  end
                  OP_LDI: rf_next[rdi] = kimm;
                  OP_SBI: begin
                     alu = add_sub(rf_reg[rdi], kimm, 1'b0, 1'b1);
                     rf_next[rdi] = alu.res;
                     upd_znv = 1'b1;
                     upd_c   = 1'b1;
                     upd_h   = 1'b1;
                  end
                  OP_LD, OP_ST: begin
                     // X, Y or Z as 16-bit data pointer [RULE8]
                     unique case (ir_reg[11:10])
                        2'b00:   ptr = `R8DP_PTR_X;
                        2'b01:   ptr = `R8DP_PTR_Y;
                        default: ptr = `R8DP_PTR_Z;
                     endcase
                     dbus_next.addr = pair16(ptr);  // [RULE1]
                     if (op == OP_LD) begin
                        dbus_next.re = 1'b1;
                        dst_next     = rd;
                        state_next   = ST_LOAD;
                        stall        = 1'b1;  // Data arrives next cycle
                     end else begin
                        dbus_next.wdata = b;
                        dbus_next.we    = 1'b1;
                     end
                  end
                  OP_TBL: begin
                     // Flash table byte addressed by Z [RULE9]
                     dst_next   = rd;
                     target     = pair16(`R8DP_PTR_Z) >> 1;
                     redirect   = 1'b1;
                     state_next = ST_TBL;
                     dbus_next.addr = paddr_reg;  // Return point parked in the idle lane
                  end
                  OP_JMP: begin
                     target   = paddr_reg + {{4{ir_reg[11]}}, ir_reg[11:0]};
                     redirect = 1'b1;
                  end
                  OP_BRS, OP_BRC: begin
                     target   = paddr_reg + {{7{ir_reg[8]}}, ir_reg[8:0]};
                     redirect = (status_flags_register_reg[ir_reg[11:9]] == (op == OP_BRS));
                  end
                  default: ;  // Nop and spare codes
               endcase
            end
         end
         ST_LOAD: begin
            rf_next[dst_reg] = DATA_RDATA;
            state_next       = ST_RUN;
         end
         default: begin
            // Byte select by Z bit 0, then resume after the table read
            rf_next[dst_reg] = rf_reg[`R8DP_PTR_Z][0] ? PROG_DATA[15:8] : PROG_DATA[7:0];
            target     = dbus_reg.addr;
            redirect   = 1'b1;
            state_next = ST_RUN;
         end
      endcase
      if (upd_znv) begin  // [RULE11]
         nf = upd_c && op == OP_ONE && ir_reg[11:10] == 2'b10 ? 1'b0 : alu.res[7];
         zf = (op == OP_ADW) ? (wsum[15:0] == 16'h0000) : (alu.res == 8'h00);
         vf = alu.v;
         status_flags_register_next[`R8DP_FLAG_N] = nf;
         status_flags_register_next[`R8DP_FLAG_V] = vf;
         status_flags_register_next[`R8DP_FLAG_S] = nf ^ vf;  // [RULE12]
      end
      if (upd_znv || op == OP_MUL && state_reg == ST_RUN && irv_reg) begin
         status_flags_register_next[`R8DP_FLAG_Z] = zf;  // [RULE11]
      end
      if (upd_c) begin
         status_flags_register_next[`R8DP_FLAG_C] = (op == OP_MUL) ? cf : alu.c;
      end
      if (upd_h) begin
         status_flags_register_next[`R8DP_FLAG_H] = alu.h;
      end
      if (redirect) begin
         // Drop the prefetched word, fetch the target next [RULE13]
         paddr_next = target;
         irv_next   = 1'b0;
      end else if (!stall) begin
         // Overlapped fetch gives one instruction per clock [RULE2] [RULE3]
         ir_next    = PROG_DATA;
         irv_next   = 1'b1;
         paddr_next = paddr_reg + 16'h0001;
      end
   end

   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int i = 0; i < `R8DP_NREGS; i++) begin
            rf_reg[i] <= 8'h00;  // [RULE4]
         end
         status_flags_register_reg <= `R8DP_FLAGS_RST;
         paddr_reg <= `R8DP_PC_RST;
         ir_reg    <= `R8DP_IR_RST;
         irv_reg   <= 1'b0;
         dst_reg   <= 5'h00;
         state_reg <= ST_RUN;
         dbus_reg  <= '0;
      end else begin
         rf_reg    <= rf_next;  // Single-cycle write back [RULE5]
         status_flags_register_reg <= status_flags_register_next;
         paddr_reg <= paddr_next;
         ir_reg    <= ir_next;
         irv_reg   <= irv_next;
         dst_reg   <= dst_next;
         state_reg <= state_next;
         dbus_reg  <= dbus_next;
      end
   end

   assign PROG_ADDR    = paddr_reg;
   assign DATA_BUS     = dbus_reg;
   assign STATUS_FLAGS = status_flags_register_reg;
endmodule

// ### testbench/r8dp_mem.sv
// Flash and data memory model on the far side of the core.
// Assumes the bench preloads rom and dmem by hierarchical name.
`timescale 1ns/1ps
module r8dp_mem
   import r8dp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [15:0] prog_addr,
   output logic [15:0]      prog_data,
   input  wire r8dp_dbus_t  dbus,
   output logic [7:0]       rdata
);
   logic [15:0] rom  [0:255];
   logic [7:0]  dmem [0:65535];
   logic [7:0]  last_q = 8'h00;

   // Own port per space, both answer in one cycle
   assign prog_data = rom[prog_addr[7:0]]; // Table bytes come the same way
   // Idle line shows inverse of last byte, so a stale value never matches
   assign rdata = dbus.re ? dmem[dbus.addr] : ~last_q;

   always @(posedge clk) begin
      if (dbus.re) begin
         last_q <= dmem[dbus.addr];
      end
      if (dbus.we) begin
         dmem[dbus.addr] <= dbus.wdata;
      end
   end
endmodule

// ### testbench/r8dp_core_asserts.sv
// Port checker for the core datapath, bound into r8dp_core.
// Assumes a single MCLK domain and active-low RST_B.
`timescale 1ns/1ps
module r8dp_core_checker
   import r8dp_pkg::*;
(
   input wire logic        MCLK,
   input wire logic        RST_B,
   input wire logic [15:0] PROG_ADDR,
   input wire logic [15:0] PROG_DATA,
   input wire r8dp_dbus_t  DATA_BUS,
   input wire logic [7:0]  DATA_RDATA,
   input wire logic [7:0]  STATUS_FLAGS
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   a_sign_is_nxv: assert property (
      STATUS_FLAGS[4] == (STATUS_FLAGS[2] ^ STATUS_FLAGS[3]))
      else $error("sign flag differs from N xor V");
   a_no_we_re: assert property (!(DATA_BUS.we && DATA_BUS.re))
      else $error("read and write strobes together");
   a_load_pulse: assert property (DATA_BUS.re |=> !DATA_BUS.re)
      else $error("read strobe longer than one cycle");
   a_reset_clear: assert property ($rose(RST_B) |->
      PROG_ADDR == 16'h0000 && STATUS_FLAGS == 8'h00 && DATA_BUS == '0)
      else $error("outputs not cleared by reset");
   a_fetch_start: assert property ($rose(RST_B) |=> PROG_ADDR == 16'h0001)
      else $error("fetch pointer not 1 after first edge");
   a_fetch_moves: assert property ($stable(PROG_ADDR)[*2] |=> !$stable(PROG_ADDR))
      else $error("fetch pointer stalled too long");
   a_wdata_stands: assert property (
      !DATA_BUS.we && !DATA_BUS.re |-> $stable(DATA_BUS.wdata))
      else $error("store data moved without access");
   a_flags_quiet: assert property (
      DATA_BUS.we || DATA_BUS.re |-> $stable(STATUS_FLAGS))
      else $error("flags changed by memory access");
   a_jump_target: assert property (
      PROG_DATA[15:12] == 4'hB ##1 PROG_ADDR == $past(PROG_ADDR) + 16'h0001 |=>
      PROG_ADDR == $past(PROG_ADDR, 2) + 16'h0001
         + {{4{$past(PROG_DATA[11], 2)}}, $past(PROG_DATA[11:0], 2)})
      else $error("jump did not reach its target");
endmodule

bind r8dp_core r8dp_core_checker u_chk (.MCLK(MCLK), .RST_B(RST_B), .PROG_ADDR(PROG_ADDR),
   .PROG_DATA(PROG_DATA), .DATA_BUS(DATA_BUS), .DATA_RDATA(DATA_RDATA),
   .STATUS_FLAGS(STATUS_FLAGS));

// ### testbench/tb_risc8_core_datapath.sv
// Self-checking bench: ALU rows, then pointer, table and jump case, then word, immediate and branch case.
// Assumes r8dp_mem stands in for flash and data memory.
`timescale 1ns/1ps
module tb_risc8_core_datapath
   import r8dp_pkg::*;
;
   typedef struct packed {
      logic [3:0] op;
      logic [1:0] sub;
      logic [7:0] a;
      logic [7:0] b;
      logic [4:0] st_src;
      logic [7:0] res;
      logic [7:0] flg;
   } r8dp_row_t;

   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [15:0] prog_addr;
   logic [15:0] prog_data;
   r8dp_dbus_t  data_bus;
   logic [7:0]  data_rdata;
   logic [7:0]  status_flags;
   int          mismatches = 0;
   int          checks_done = 0;
   int          n;
   // Flags start clear after reset, so carry-in is 0 in every row
   r8dp_row_t   rows [13] = '{
      '{4'h1, 2'h0, 8'h7F, 8'h01, 5'h10, 8'h80, 8'h2C},
      '{4'h1, 2'h1, 8'hFF, 8'h01, 5'h10, 8'h00, 8'h23},
      '{4'h1, 2'h2, 8'h10, 8'h20, 5'h10, 8'hF0, 8'h15},
      '{4'h1, 2'h3, 8'h80, 8'h01, 5'h10, 8'h7F, 8'h38},
      '{4'h2, 2'h0, 8'hF0, 8'h0F, 5'h10, 8'h00, 8'h02},
      '{4'h2, 2'h1, 8'h80, 8'h01, 5'h10, 8'h81, 8'h14},
      '{4'h2, 2'h2, 8'h0F, 8'hF0, 5'h10, 8'hFF, 8'h14},
      '{4'h2, 2'h3, 8'h00, 8'h5A, 5'h10, 8'h5A, 8'h00},
      '{4'h3, 2'h0, 8'h7F, 8'h00, 5'h10, 8'h80, 8'h0C},
      '{4'h3, 2'h1, 8'h00, 8'h00, 5'h10, 8'hFF, 8'h14},
      '{4'h3, 2'h2, 8'h01, 8'h00, 5'h10, 8'h00, 8'h1B},
      '{4'h3, 2'h3, 8'h0F, 8'h00, 5'h10, 8'hF0, 8'h15},
      '{4'h4, 2'h0, 8'hFF, 8'hFF, 5'h01, 8'hFE, 8'h01}};

   always #10 mclk = ~mclk;

   r8dp_core dut (.MCLK(mclk), .RST_B(rst_b), .PROG_ADDR(prog_addr), .PROG_DATA(prog_data),
      .DATA_BUS(data_bus), .DATA_RDATA(data_rdata), .STATUS_FLAGS(status_flags));
   r8dp_mem u_mem (.clk(mclk), .prog_addr(prog_addr), .prog_data(prog_data), .dbus(data_bus),
      .rdata(data_rdata));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic clear_rom();
      for (int i = 0; i < 256; i++) begin
         u_mem.rom[i] = 16'h0000;
      end
   endtask

   // Reset held two cycles, values looked at while still held
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      check(prog_addr, 16'h0000);
      check(data_bus.addr, 16'h0000);
      check({8'h00, status_flags}, 16'h0000);
      rst_b = 1'b1;
   endtask

   // Counts edges until a store strobe shows, bounded
   task automatic wait_we(output int cnt);
      cnt = 0;
      do begin
         @(posedge mclk);
         #1;
         cnt++;
      end while (data_bus.we !== 1'b1 && cnt < 50);
      if (cnt >= 50) begin
         mismatches++;
         $display("ERROR t=%0t store strobe missing got=%h exp=%h", $time, 1'b0, 1'b1);
         stop_test();
      end
   endtask

   initial begin
      for (int i = 0; i < 13; i++) begin
         clear_rom();
         u_mem.rom[0] = {8'h60, rows[i].a};
         u_mem.rom[1] = {8'h61, rows[i].b};
         u_mem.rom[2] = {8'h6A, 8'h40 + 8'(i)};
         u_mem.rom[3] = 16'h6B00;
         u_mem.rom[4] = {rows[i].op, rows[i].sub, 5'h10, 5'h11};
         u_mem.rom[5] = {6'h24, 5'h00, rows[i].st_src};
         u_mem.rom[6] = 16'hBFFF;
         do_reset();
         wait_we(n);
         check(16'(n), 16'h0007);
         check({8'h00, data_bus.wdata}, {8'h00, rows[i].res});
         check(data_bus.addr, {8'h00, 8'h40 + 8'(i)});
         check({8'h00, status_flags}, {8'h00, rows[i].flg});
         $display("row %0d done", i);
      end
      // Load via Y, table via Z, jump over a poisoning load
      clear_rom();
      u_mem.rom[0] = 16'h6C34;
      u_mem.rom[1] = 16'h6D12;
      u_mem.rom[2] = 16'h8640;
      u_mem.rom[3] = 16'h6E21;
      u_mem.rom[4] = 16'h6F00;
      u_mem.rom[5] = 16'hA260;
      u_mem.rom[6] = 16'hB001;
      u_mem.rom[7] = 16'h62FF;
      u_mem.rom[8] = 16'h9012;
      u_mem.rom[9] = 16'h9813;
      u_mem.rom[10] = 16'hBFFF;
      u_mem.rom[16] = 16'h3C96;
      u_mem.dmem[16'h1234] = 8'hC3;
      do_reset();
      wait_we(n);
      check(data_bus.addr, 16'h0000);
      check({8'h00, data_bus.wdata}, 16'h00C3);
      wait_we(n);
      check(16'(n), 16'h0001);
      check(data_bus.addr, 16'h0021);
      check({8'h00, data_bus.wdata}, 16'h003C);
      $display("pointer and table case done");
      // Word add, immediate subtract, taken branch over a poison store, untaken branch
      clear_rom();
      u_mem.rom[0] = 16'h68FF;
      u_mem.rom[1] = 16'h697F;
      u_mem.rom[2] = 16'h5001;
      u_mem.rom[3] = 16'h9019;
      u_mem.rom[4] = 16'h7005;
      u_mem.rom[5] = 16'hC001;
      u_mem.rom[6] = 16'h9019;
      u_mem.rom[7] = 16'hD001;
      u_mem.rom[8] = 16'h9010;
      u_mem.rom[9] = 16'hBFFF;
      do_reset();
      wait_we(n);
      check(16'(n), 16'h0005);
      check({8'h00, data_bus.wdata}, 16'h0080);
      check({8'h00, status_flags}, 16'h000C);
      wait_we(n);
      check(16'(n), 16'h0005);
      check({8'h00, data_bus.wdata}, 16'h00FB);
      check({8'h00, status_flags}, 16'h0035);
      check(prog_addr, 16'h000A);
      $display("word, immediate and branch case done");
      stop_test();
   end
endmodule
